// [design/signal_led_regs.vh]
// Register map, field layout, reset values and timing constants of the signaling LED block
`ifndef SIGNAL_LED_REGS_VH
`define SIGNAL_LED_REGS_VH

// ==================================================================
// Register byte offsets
`define RED_CTRL_OFS        8'h00
`define GREEN_CTRL_OFS      8'h04
`define BLUE_CTRL_OFS       8'h08
`define BOOST_CTRL_OFS      8'h0c
`define APPLIED_DUTY_OFS    8'h10

// ==================================================================
// Channel control fields
`define LEVEL_LSB           0
`define LEVEL_MSB           2
`define DUTY_LSB            3
`define DUTY_MSB            8
`define RAMP_BIT            9
`define PERIOD_LSB          10
`define PERIOD_MSB          11
`define LED_BOOST_BIT       12
`define CHAN_CTRL_RESET     13'h0000

// Boost control fields
`define GENERAL_BOOST_BIT   0
`define USB_BOOST_BIT       1
`define BOOST_CTRL_RESET    2'h0

// ==================================================================
// Timing
`define PCLK_HZ             200000000
`define SLOT_HZ             8192
`define RAMP_STEP_HZ        64
`define PWM_STEPS           32
`define DUTY_FULL           6'h20
`define RAMP_STEP_SLOTS     (`SLOT_HZ / `RAMP_STEP_HZ)
`define SLOT_DIV            (`PCLK_HZ / `SLOT_HZ)
`define PER_FAST_SHIFT      0
`define PER_8HZ_SHIFT       5
`define PER_1S_SHIFT        8
`define PER_2S_SHIFT        9

`endif

// [design/led_channel.v]
// One signaling LED channel: duty ramp and PWM generator
`timescale 1ns/1ps
`include "signal_led_regs.vh"
module led_channel (
   input  wire       pclk,
   input  wire       presetn,
   input  wire [5:0] chan_duty_code,
   input  wire       chan_ramp_enable,
   input  wire [1:0] chan_blink_period,
   input  wire       slot_en,
   input  wire       ramp_step,
   output reg  [5:0] applied_duty,
   output reg        sink_on
);

   // ==================================================================
   // Target duty from the code
   wire [5:0] target;
   wire       ramping;
   reg  [4:0] slot;
   reg  [5:0] next_applied;

   assign target  = chan_duty_code[5] ? `DUTY_FULL : {1'b0, chan_duty_code[4:0]};
   assign ramping = chan_ramp_enable && (chan_blink_period == 2'b00);

   // ==================================================================
   // Applied duty
   always @* begin
      next_applied = applied_duty;
      if (!ramping) begin
         next_applied = target;
      end else if (ramp_step) begin
         if (applied_duty < target) begin
            next_applied = applied_duty + 6'h01;
         end else if (applied_duty > target) begin
            next_applied = applied_duty - 6'h01;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         applied_duty <= 6'h00;
      end else begin
         applied_duty <= next_applied;
      end
   end

   // ==================================================================
   // PWM slot counter, 32 slots per period
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot    <= 5'h00;
         sink_on <= 1'b0;
      end else begin
         if (slot_en) begin
            slot <= slot + 5'h01;
         end
         sink_on <= ({1'b0, slot} < applied_duty);
      end
   end

endmodule

// [design/signal_led_pwm_ramp_blink.v]
// Top of the signaling LED block: APB registers, timebase and three channels
`timescale 1ns/1ps
`include "signal_led_regs.vh"
module signal_led_pwm_ramp_blink #(
   parameter SLOT_DIV = `SLOT_DIV
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   output wire [2:0]  red_current_level,
   output wire [2:0]  green_current_level,
   output wire [2:0]  blue_current_level,
   output wire        red_sink_on,
   output wire        green_sink_on,
   output wire        blue_sink_on,
   output reg         boost_converter_enable
);

   // ==================================================================
   // Register storage
   reg  [12:0] red_signal_channel;
   reg  [11:0] green_signal_channel;
   reg  [12:0] blue_signal_channel;
   reg  [1:0]  boost_ctrl;
   wire [5:0]  red_applied;
   wire [5:0]  green_applied;
   wire [5:0]  blue_applied;

   // ==================================================================
   // APB decode
   wire       wr_access;
   wire       setup;
   reg        addr_hit;
   reg [31:0] next_prdata;

   assign setup     = psel && !penable;
   assign wr_access = psel && penable && pwrite && addr_hit;
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !addr_hit;

   always @* begin
      case (paddr)
         `RED_CTRL_OFS:     addr_hit = 1'b1;
         `GREEN_CTRL_OFS:   addr_hit = 1'b1;
         `BLUE_CTRL_OFS:    addr_hit = 1'b1;
         `BOOST_CTRL_OFS:   addr_hit = 1'b1;
         `APPLIED_DUTY_OFS: addr_hit = 1'b1;
         default:           addr_hit = 1'b0;
      endcase
   end

   // ==================================================================
   // Register writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         red_signal_channel   <= `CHAN_CTRL_RESET;
         green_signal_channel <= 12'h000;
         blue_signal_channel  <= `CHAN_CTRL_RESET;
         boost_ctrl           <= `BOOST_CTRL_RESET;
      end else if (wr_access) begin
         case (paddr)
            `RED_CTRL_OFS: begin
               red_signal_channel <= {1'b0, pwdata[`PERIOD_MSB:`LEVEL_LSB]};
            end
            `GREEN_CTRL_OFS: begin
               green_signal_channel <= pwdata[`PERIOD_MSB:`LEVEL_LSB];
            end
            `BLUE_CTRL_OFS: begin
               blue_signal_channel <= pwdata[`LED_BOOST_BIT:`LEVEL_LSB];
            end
            `BOOST_CTRL_OFS: begin
               boost_ctrl <= pwdata[`USB_BOOST_BIT:`GENERAL_BOOST_BIT];
            end
            default: begin
               boost_ctrl <= boost_ctrl;
            end
         endcase
      end
   end

   // ==================================================================
   // Read data, captured in the setup cycle
   always @* begin
      case (paddr)
         `RED_CTRL_OFS:     next_prdata = {19'h00000, red_signal_channel};
         `GREEN_CTRL_OFS:   next_prdata = {20'h00000, green_signal_channel};
         `BLUE_CTRL_OFS:    next_prdata = {19'h00000, blue_signal_channel};
         `BOOST_CTRL_OFS:   next_prdata = {30'h00000000, boost_ctrl};
         `APPLIED_DUTY_OFS: next_prdata = {10'h000, blue_applied, 2'h0, green_applied, 2'h0, red_applied};
         default:           next_prdata = 32'h00000000;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup && !pwrite) begin
         prdata <= next_prdata;
      end
   end

   // ==================================================================
   // Boost converter enable
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boost_converter_enable <= 1'b0;
      end else begin
         boost_converter_enable <= boost_ctrl[`GENERAL_BOOST_BIT] | boost_ctrl[`USB_BOOST_BIT] |
                                   blue_signal_channel[`LED_BOOST_BIT];
      end
   end

   // ==================================================================
   // Timebase: slot tick at 8192 Hz and derived enables
   reg  [15:0] div_cnt;
   reg  [9:0]  tick_cnt;
   reg         tick;
   wire        en_8hz;
   wire        en_1s;
   wire        en_2s;
   wire        ramp_step;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt  <= 16'h0000;
         tick     <= 1'b0;
         tick_cnt <= 10'h000;
      end else begin
         if (div_cnt == SLOT_DIV[15:0] - 16'h0001) begin
            div_cnt <= 16'h0000;
            tick    <= 1'b1;
         end else begin
            div_cnt <= div_cnt + 16'h0001;
            tick    <= 1'b0;
         end
         if (tick) begin
            tick_cnt <= tick_cnt + 10'h001;
         end
      end
   end

   assign en_8hz    = tick && (tick_cnt[`PER_8HZ_SHIFT-1:0] == 5'h00);
   assign en_1s     = tick && (tick_cnt[`PER_1S_SHIFT-1:0] == 8'h00);
   assign en_2s     = tick && (tick_cnt[`PER_2S_SHIFT-1:0] == 9'h000);
   assign ramp_step = tick && (tick_cnt[6:0] == 7'h00);

   function slot_sel;
      input [1:0] per;
      input       t;
      input       e8;
      input       e1;
      input       e2;
      begin
         case (per)
            2'b00:   slot_sel = t;
            2'b01:   slot_sel = e8;
            2'b10:   slot_sel = e1;
            2'b11:   slot_sel = e2;
            default: slot_sel = t;
         endcase
      end
   endfunction

   // ==================================================================
   // Channels; sink on pulls the output low, so it doubles as open-drain or PWM
   assign red_current_level   = red_signal_channel[`LEVEL_MSB:`LEVEL_LSB];
   assign green_current_level = green_signal_channel[`LEVEL_MSB:`LEVEL_LSB];
   assign blue_current_level  = blue_signal_channel[`LEVEL_MSB:`LEVEL_LSB];

   led_channel u_red (
      .pclk              (pclk),
      .presetn           (presetn),
      .chan_duty_code    (red_signal_channel[`DUTY_MSB:`DUTY_LSB]),
      .chan_ramp_enable  (red_signal_channel[`RAMP_BIT]),
      .chan_blink_period (red_signal_channel[`PERIOD_MSB:`PERIOD_LSB]),
      .slot_en           (slot_sel(red_signal_channel[`PERIOD_MSB:`PERIOD_LSB], tick, en_8hz, en_1s, en_2s)),
      .ramp_step         (ramp_step),
      .applied_duty      (red_applied),
      .sink_on           (red_sink_on)
   );

   led_channel u_green (
      .pclk              (pclk),
      .presetn           (presetn),
      .chan_duty_code    (green_signal_channel[`DUTY_MSB:`DUTY_LSB]),
      .chan_ramp_enable  (green_signal_channel[`RAMP_BIT]),
      .chan_blink_period (green_signal_channel[`PERIOD_MSB:`PERIOD_LSB]),
      .slot_en           (slot_sel(green_signal_channel[`PERIOD_MSB:`PERIOD_LSB], tick, en_8hz, en_1s, en_2s)),
      .ramp_step         (ramp_step),
      .applied_duty      (green_applied),
      .sink_on           (green_sink_on)
   );

   led_channel u_blue (
      .pclk              (pclk),
      .presetn           (presetn),
      .chan_duty_code    (blue_signal_channel[`DUTY_MSB:`DUTY_LSB]),
      .chan_ramp_enable  (blue_signal_channel[`RAMP_BIT]),
      .chan_blink_period (blue_signal_channel[`PERIOD_MSB:`PERIOD_LSB]),
      .slot_en           (slot_sel(blue_signal_channel[`PERIOD_MSB:`PERIOD_LSB], tick, en_8hz, en_1s, en_2s)),
      .ramp_step         (ramp_step),
      .applied_duty      (blue_applied),
      .sink_on           (blue_sink_on)
   );

endmodule

// [tb/signal_led_assertions.sv]
// Port checker for the signaling LED block
`timescale 1ns/1ps
module signal_led_checks (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [2:0]  red_current_level,
   input wire [2:0]  green_current_level,
   input wire [2:0]  blue_current_level,
   input wire        red_sink_on,
   input wire        blue_sink_on,
   input wire        boost_converter_enable
);
   // ==========================================
   // Write strobes and boost request shadow
   wire      wr = psel & penable & pwrite;
   wire      wr_r = wr && paddr == 8'h00;
   wire      wr_g = wr && paddr == 8'h04;
   wire      wr_b = wr && paddr == 8'h08;
   reg [2:0] bq;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) bq <= 3'h0;
      else if (wr && paddr == 8'h0c) bq[1:0] <= pwdata[1:0];
      else if (wr_b) bq[2] <= pwdata[12];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================
   // Assertions
   AST_LEVEL_RED: assert property (wr_r |=> red_current_level == $past(pwdata[2:0]))
      else $error("red level not taken");
   AST_LEVEL_BLUE: assert property (wr_b |=> blue_current_level == $past(pwdata[2:0]))
      else $error("blue level not taken");
   AST_LEVEL_HOLD: assert property (!(wr_r | wr_g | wr_b) |=>
      $stable({red_current_level, green_current_level, blue_current_level}))
      else $error("level moved without write");
   AST_BOOST: assert property (boost_converter_enable != |bq |=> boost_converter_enable == |bq)
      else $error("boost enable not OR of requests");
   AST_BOOST_LED: assert property (wr_b && pwdata[12] |-> ##2 boost_converter_enable)
      else $error("blue boost request ignored");
   AST_FULL_ON: assert property (wr_r && pwdata[8] && !pwdata[9] |-> ##3 red_sink_on [*4])
      else $error("full duty not on");
   AST_OFF: assert property (wr_r && pwdata[8:3] == 6'h00 && !pwdata[9] |-> ##3 (!red_sink_on) [*4])
      else $error("zero duty not off");
   AST_BLINK: assert property (wr_b && pwdata[8] && pwdata[9] && pwdata[11:10] != 2'b00
      |-> ##3 blue_sink_on [*4]) else $error("blink duty ramped");
   cover property (wr_b && pwdata[12]);
   cover property (red_sink_on);
   cover property (boost_converter_enable);
endmodule
bind signal_led_pwm_ramp_blink signal_led_checks chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .red_current_level, .green_current_level, .blue_current_level, .red_sink_on, .blue_sink_on,
   .boost_converter_enable);

// [tb/led_load.sv]
// Pulled-up open-drain loads on the three channel outputs
`timescale 1ns/1ps
module led_load (
   input  wire logic [2:0] sink_on,
   input  wire logic [2:0] level,
   output logic [2:0]      pin_high,
   output logic [4:0]      red_ma
);
   // Pull-up wins unless the sink conducts
   assign pin_high = ~sink_on;
   assign red_ma = sink_on[0] ? level * 5'd3 : 5'd0;
endmodule

// [tb/signal_led_pwm_ramp_blink_test.sv]
// Self-checking bench for the signaling LED block
`timescale 1ns/1ps
`include "signal_led_regs.vh"
module signal_led_pwm_ramp_blink_test;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  red_current_level, green_current_level, blue_current_level, pin_high;
   logic        red_sink_on, green_sink_on, blue_sink_on, boost_converter_enable;
   logic [4:0]  red_ma;
   int          err_total, compares, cyc, hi, per;
   int          tps [4] = '{1, 32, 256, 512};
   signal_led_pwm_ramp_blink #(.SLOT_DIV(2)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .red_current_level, .green_current_level, .blue_current_level,
      .red_sink_on, .green_sink_on, .blue_sink_on, .boost_converter_enable);
   led_load load (.sink_on({blue_sink_on, green_sink_on, red_sink_on}), .level(red_current_level),
      .pin_high, .red_ma);
   // ==========================================
   // Tasks
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata; er = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   function automatic logic [31:0] ctl(input int lv, input int dc, input int rp, input int pr);
      return 32'(lv + dc * 8 + rp * 512 + pr * 1024);
   endfunction
   task automatic wrap_up;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      pclk = 0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 99000) begin
         err_total++;
         wrap_up;
      end
   end
   // ==========================================
   // Tests
   initial begin
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      err_total = 0; compares = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1;
      for (int a = 0; a <= 8'h14; a += 4) begin
         xfer(0, 8'(a), 0);
         check("reset value", rd, 0);
         check("slave error", er, a == 8'h14);
      end
      xfer(1, 8'h14, 32'hffffffff);
      check("unmapped write", er, 1);
      // Color by level, brightness by duty
      xfer(1, `RED_CTRL_OFS, ctl(7, 32, 0, 0));
      xfer(1, `GREEN_CTRL_OFS, ctl(3, 0, 0, 0));
      repeat (6) @(posedge pclk);
      check("red mA", red_ma, 21);
      check("green level", green_current_level, 3);
      check("red pin", pin_high[0], 0);
      xfer(1, `RED_CTRL_OFS, ctl(7, 0, 0, 0));
      repeat (6) @(posedge pclk);
      check("red pin off", pin_high[0], 1);
      for (int i = 0; i < 3; i++) begin
         xfer(1, i < 2 ? `BOOST_CTRL_OFS : `BLUE_CTRL_OFS, i < 2 ? 1 << i : 32'h1000);
         repeat (2) @(posedge pclk);
         check("boost on", boost_converter_enable, 1);
         xfer(1, i < 2 ? `BOOST_CTRL_OFS : `BLUE_CTRL_OFS, 0);
         repeat (2) @(posedge pclk);
         check("boost off", boost_converter_enable, 0);
      end
      xfer(1, `GREEN_CTRL_OFS, ctl(3, 16, 0, 0));
      xfer(0, `APPLIED_DUTY_OFS, 0);
      check("green applied", rd[13:8], 16);
      xfer(1, `GREEN_CTRL_OFS, ctl(3, 63, 0, 0));
      xfer(1, `APPLIED_DUTY_OFS, 0);
      check("read-only error", er, 0);
      xfer(0, `APPLIED_DUTY_OFS, 0);
      check("green full", rd[13:8], 32);
      check("green pin", pin_high[1], 0);
      // Ramp: one step every 256 clocks here
      xfer(1, `BLUE_CTRL_OFS, ctl(0, 3, 1, 0));
      xfer(0, `APPLIED_DUTY_OFS, 0);
      check("blue early", rd[21:16] <= 1, 1);
      repeat (1000) @(posedge pclk);
      xfer(0, `APPLIED_DUTY_OFS, 0);
      check("blue stop", rd[21:16], 3);
      xfer(1, `BLUE_CTRL_OFS, ctl(0, 9, 1, 0));
      repeat (1024) @(posedge pclk);
      xfer(0, `APPLIED_DUTY_OFS, 0);
      check("blue mid", rd[21:16] >= 6 && rd[21:16] <= 8, 1);
      xfer(1, `BLUE_CTRL_OFS, ctl(0, 2, 1, 0));
      repeat (1800) @(posedge pclk);
      xfer(0, `APPLIED_DUTY_OFS, 0);
      check("blue redirect", rd[21:16], 2);
      xfer(1, `BLUE_CTRL_OFS, ctl(0, 32, 1, 1));
      xfer(0, `APPLIED_DUTY_OFS, 0);
      check("blue blink", rd[21:16], 32);
      for (int p = 0; p < 4; p++) begin
         xfer(1, `RED_CTRL_OFS, ctl(1, 8, 0, p));
         @(negedge pclk);
         while (red_sink_on !== 1'b0) @(negedge pclk);
         while (red_sink_on !== 1'b1) @(negedge pclk);
         hi = 0; per = 0;
         while (red_sink_on === 1'b1) begin hi++; per++; @(negedge pclk); end
         while (red_sink_on === 1'b0 && p < 3) begin per++; @(negedge pclk); end
         check("on time", hi, 16 * tps[p]);
         if (p < 3) check("period", per, 64 * tps[p]);
         @(posedge pclk);
      end
      wrap_up;
   end
endmodule
